// file: verilog/frc_ctrl.sv
// Flash rewrite sequencer control with interrupt suspend and abort handling
`timescale 1ns/1ps
module frc_ctrl
   import frc_pkg::*;
#(
   parameter int BLK_WIDTH = frc_pkg::BLK_W
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic cmd_start, // Start pulse for erase or program
   input wire frc_pkg::frc_op_t cmd_op, // Operation kind
   input wire logic cmd_prog_area, // Target is program area
   input wire logic [BLK_WIDTH-1:0] cmd_block, // Target block
   input wire logic flash_op_done, // Flash core finished current operation
   input wire logic irq_accept, // Maskable interrupt accepted
   input wire logic nmi_accept, // Watchdog, oscillator or voltage interrupt
   input wire logic xfer_active, // Transfer controller activity
   input wire logic susp_wr_en, // Write strobe for suspend request
   input wire logic susp_wr_val, // Value written to suspend request
   input wire logic [frc_pkg::NUM_SET_BITS-1:0] set_wr_en, // Set-protected writes
   input wire logic [frc_pkg::NUM_SET_BITS-1:0] set_wr_val, // Set-protected values
   input wire logic [frc_pkg::NUM_CLR_BITS-1:0] lock_wr_en, // Lock bit writes
   input wire logic [frc_pkg::NUM_CLR_BITS-1:0] lock_wr_val, // Lock bit values
   input wire logic [BLK_WIDTH-1:0] acc_block, // Block being accessed
   output logic erase_suspend_request, // Suspend request bit
   output logic flash_ready_flag, // 1 ready, 0 busy
   output logic erase_suspended, // Erase halted in suspend
   output logic erase_run, // Flash core erasing or programming
   output logic flash_reset, // Forced flash reset pulse
   output logic irq_hold, // Interrupt handling held off
   output logic acc_allowed, // Access to acc_block permitted
   output logic watchdog_run, // Watchdog keeps counting
   output logic [frc_pkg::NUM_SET_BITS-1:0] mode_bits, // Set-protected bits
   output logic [frc_pkg::NUM_CLR_BITS-1:0] lock_bits // Block lock bits
);
   frc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic susp_reg, susp_next;
   logic prog_area_reg, prog_area_next;
   logic [BLK_WIDTH-1:0] blk_reg, blk_next;
   logic acc_reg, acc_next;
   logic rst_pulse_reg, rst_pulse_next;
   logic intervene;
   logic susp_auto;
   frc_wr_if #(.W(NUM_SET_BITS)) set_if ();
   frc_wr_if #(.W(NUM_CLR_BITS)) clr_if ();
   assign intervene = irq_accept | nmi_accept | xfer_active;
   assign set_if.wr_en = set_wr_en;
   assign set_if.wr_val = set_wr_val;
   assign clr_if.wr_en = lock_wr_en;
   assign clr_if.wr_val = lock_wr_val;
   // ************************************************
   // Protected mode bits
   // ************************************************
   // Set-protected bits: 0 then 1
   frc_prot_bits #(.W(NUM_SET_BITS), .RST_VAL(SET_BITS_RST), .ARM_VAL(1'b0)) u_set (
      .clk(clk),
      .sys_rst(sys_rst),
      .intervene(intervene),
      .wr(set_if.guard)
   );
   // Lock bits: 1 then 0
   frc_prot_bits #(.W(NUM_CLR_BITS), .RST_VAL(CLR_BITS_RST), .ARM_VAL(1'b1)) u_clr (
      .clk(clk),
      .sys_rst(sys_rst),
      .intervene(intervene),
      .wr(clr_if.guard)
   );
   assign susp_auto = set_if.bits[SB_SUSP_ON_INT];
   // ************************************************
   // Sequencer
   // ************************************************
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      susp_next = susp_reg;
      prog_area_next = prog_area_reg;
      blk_next = blk_reg;
      rst_pulse_next = 1'b0;
      // Software write of suspend request
      if (susp_wr_en) begin
         susp_next = susp_wr_val;
      end
      unique case (state_reg)
         FRC_IDLE: begin
            susp_next = 1'b0;
            if (cmd_start) begin
               prog_area_next = cmd_prog_area;
               blk_next = cmd_block;
               state_next = (cmd_op == FRC_OP_ERASE) ? FRC_ERASE : FRC_PROGRAM;
            end
         end
         FRC_ERASE: begin
            if (prog_area_reg && nmi_accept) begin
               state_next = FRC_RESTART;
               cnt_next = CNT_W'(RESTART_DELAY_CYC);
               rst_pulse_next = 1'b1;
            end else if (flash_op_done) begin
               state_next = FRC_IDLE;
            end else begin
               // Hardware set beats software clear in same cycle
               if (irq_accept && susp_auto && set_if.bits[SB_SUSP_FUNC]) begin
                  susp_next = 1'b1;
               end
               if (susp_next) begin
                  state_next = FRC_SUSP_WAIT;
                  cnt_next = CNT_W'(SUSPEND_LATENCY_CYC);
               end
            end
         end
         FRC_SUSP_WAIT: begin
            cnt_next = cnt_reg - CNT_W'(1);
            if (cnt_reg == CNT_W'(1)) begin
               state_next = FRC_SUSPENDED;
            end
         end
         FRC_SUSPENDED: begin
            if (!susp_reg) begin
               state_next = FRC_ERASE;
            end
         end
         FRC_PROGRAM: begin
            if (prog_area_reg && nmi_accept) begin
               state_next = FRC_RESTART;
               cnt_next = CNT_W'(RESTART_DELAY_CYC);
               rst_pulse_next = 1'b1;
            end else if (flash_op_done) begin
               state_next = FRC_IDLE;
            end
         end
         FRC_RESTART: begin
            cnt_next = cnt_reg - CNT_W'(1);
            if (cnt_reg == CNT_W'(1)) begin
               state_next = FRC_IDLE;
            end
         end
         default: begin
            state_next = FRC_IDLE;
         end
      endcase
      // Block access while suspended excludes the erased block
      acc_next = (state_next != FRC_SUSPENDED && state_next != FRC_IDLE) ? 1'b0 :
         (state_next == FRC_IDLE) ? 1'b1 : (acc_block != blk_next);
   end
   // Registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= FRC_IDLE;
         cnt_reg <= '0;
         susp_reg <= 1'b0;
         prog_area_reg <= 1'b0;
         blk_reg <= '0;
         acc_reg <= 1'b1;
         rst_pulse_reg <= 1'b0;
         erase_suspend_request <= 1'b0;
         flash_ready_flag <= 1'b1;
         erase_suspended <= 1'b0;
         erase_run <= 1'b0;
         irq_hold <= 1'b0;
         watchdog_run <= 1'b1;
         mode_bits <= SET_BITS_RST;
         lock_bits <= CLR_BITS_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         susp_reg <= susp_next;
         prog_area_reg <= prog_area_next;
         blk_reg <= blk_next;
         acc_reg <= acc_next;
         rst_pulse_reg <= rst_pulse_next;
         erase_suspend_request <= susp_next;
         flash_ready_flag <= (state_next == FRC_IDLE) || (state_next == FRC_SUSPENDED);
         erase_suspended <= (state_next == FRC_SUSPENDED);
         erase_run <= (state_next == FRC_ERASE) || (state_next == FRC_SUSP_WAIT) ||
            (state_next == FRC_PROGRAM);
         irq_hold <= (state_next == FRC_RESTART);
         watchdog_run <= 1'b1;
         mode_bits <= set_if.bits;
         lock_bits <= clr_if.bits;
      end
   end
   assign flash_reset = rst_pulse_reg;
   assign acc_allowed = acc_reg;
   // ************************************************
   // Checks
   // ************************************************
   sequence s_auto_susp;
      state_reg == FRC_ERASE && irq_accept && susp_auto && set_if.bits[SB_SUSP_FUNC]
         && !nmi_accept && !flash_op_done;
   endsequence
   property p_auto_susp;
      @(posedge clk) disable iff (sys_rst) s_auto_susp |=> erase_suspend_request;
   endproperty
   a_auto_susp: assert property (p_auto_susp)
      else $error("Auto suspend request not set");
   // Cycle counters behind the latency checks
   logic [CNT_W-1:0] chk_wait_reg;
   logic [CNT_W-1:0] chk_wait_next;
   logic [CNT_W-1:0] chk_hold_reg;
   logic [CNT_W-1:0] chk_hold_next;
   always_comb begin
      chk_wait_next = (state_reg == FRC_SUSP_WAIT) ? chk_wait_reg + CNT_W'(1) : '0;
      chk_hold_next = irq_hold ? chk_hold_reg + CNT_W'(1) : '0;
   end
   // Check counter registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chk_wait_reg <= '0;
         chk_hold_reg <= '0;
      end else begin
         chk_wait_reg <= chk_wait_next;
         chk_hold_reg <= chk_hold_next;
      end
   end
   property p_susp_latency;
      @(posedge clk) disable iff (sys_rst)
      $rose(erase_suspended) |-> chk_wait_reg == CNT_W'(SUSPEND_LATENCY_CYC);
   endproperty
   a_susp_latency: assert property (p_susp_latency)
      else $error("Suspend latency wrong");
   property p_susp_bound;
      @(posedge clk) disable iff (sys_rst)
      chk_wait_reg <= CNT_W'(SUSPEND_LATENCY_CYC);
   endproperty
   a_susp_bound: assert property (p_susp_bound)
      else $error("Suspend wait too long");
   property p_access;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == FRC_SUSPENDED && acc_block == blk_reg && $stable(acc_block))
      |-> !acc_allowed;
   endproperty
   a_access: assert property (p_access)
      else $error("Access to suspended block allowed");
   property p_resume;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == FRC_SUSPENDED && !susp_reg) |=> state_reg == FRC_ERASE;
   endproperty
   a_resume: assert property (p_resume)
      else $error("Erase did not resume");
   property p_prog_runs;
      @(posedge clk) disable iff (sys_rst)
      (state_reg == FRC_PROGRAM && irq_accept && !nmi_accept && !flash_op_done)
      |=> state_reg == FRC_PROGRAM;
   endproperty
   a_prog_runs: assert property (p_prog_runs)
      else $error("Program stopped by maskable interrupt");
   property p_abort;
      @(posedge clk) disable iff (sys_rst)
      ((state_reg == FRC_ERASE || state_reg == FRC_PROGRAM) && prog_area_reg && nmi_accept)
      |=> flash_reset && irq_hold && !erase_run;
   endproperty
   a_abort: assert property (p_abort)
      else $error("Forced abort missing");
   property p_restart_delay;
      @(posedge clk) disable iff (sys_rst)
      $fell(irq_hold) |-> chk_hold_reg == CNT_W'(RESTART_DELAY_CYC);
   endproperty
   a_restart_delay: assert property (p_restart_delay)
      else $error("Restart delay wrong");
   property p_hold_bound;
      @(posedge clk) disable iff (sys_rst)
      chk_hold_reg <= CNT_W'(RESTART_DELAY_CYC);
   endproperty
   a_hold_bound: assert property (p_hold_bound)
      else $error("Interrupt hold too long");
   property p_wdt;
      @(posedge clk) disable iff (sys_rst) erase_run |-> watchdog_run;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("Watchdog stopped during command");
endmodule

// file: include/frc_pkg.sv
// Package with constants and types for the flash rewrite interrupt controller
package frc_pkg;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SUSPEND_LATENCY_NS = 20;
   localparam int SUSPEND_LATENCY_CYC =
      (SUSPEND_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESTART_DELAY_NS = 40;
   localparam int RESTART_DELAY_CYC =
      (RESTART_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   localparam int BLK_W = 4;
   // ************************************************
   // Protected bits: index positions in the mode bit vectors
   // ************************************************
   localparam int NUM_SET_BITS = 6;
   localparam int SB_CPU_REWRITE = 0;
   localparam int SB_MODE_SELECT = 1;
   localparam int SB_LOCK_CTRL = 2;
   localparam int SB_SUSP_FUNC = 3;
   localparam int SB_SUSP_ON_INT = 4;
   localparam int SB_LOW_CURRENT = 5;
   localparam int NUM_CLR_BITS = 4;
   localparam logic [NUM_SET_BITS-1:0] SET_BITS_RST = 6'h00;
   localparam logic [NUM_CLR_BITS-1:0] CLR_BITS_RST = 4'hF;
   // ************************************************
   // Sequencer states
   // ************************************************
   typedef enum logic [2:0] {
      FRC_IDLE = 3'b000,
      FRC_ERASE = 3'b001,
      FRC_SUSP_WAIT = 3'b010,
      FRC_SUSPENDED = 3'b011,
      FRC_PROGRAM = 3'b100,
      FRC_RESTART = 3'b101
   } frc_state_t;
   typedef enum logic {
      FRC_OP_ERASE = 1'b0,
      FRC_OP_PROGRAM = 1'b1
   } frc_op_t;
endpackage

// file: include/frc_wr_if.sv
// Interface carrying protected-bit write strobes to the write guard
`timescale 1ns/1ps
interface frc_wr_if #(parameter int W = 1);
   logic [W-1:0] wr_en;
   logic [W-1:0] wr_val;
   logic [W-1:0] bits;
   modport ctrl (output wr_en, output wr_val, input bits);
   modport guard (input wr_en, input wr_val, output bits);
endinterface

// file: verilog/frc_prot_bits.sv
// Protected mode bits that accept the non-arming value only after an opposite write
`timescale 1ns/1ps
module frc_prot_bits #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0,
   parameter logic ARM_VAL = 1'b0
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic intervene, // Interrupt or transfer activity between writes
   frc_wr_if.guard wr // Write strobes and bit values
);
   logic [W-1:0] val_reg;
   logic [W-1:0] val_next;
   logic [W-1:0] arm_reg;
   logic [W-1:0] arm_next;
   assign wr.bits = val_reg;
   // ************************************************
   // Per-bit unlock sequence
   // ************************************************
   always_comb begin
      val_next = val_reg;
      arm_next = arm_reg;
      for (int i = 0; i < W; i++) begin
         if (wr.wr_en[i]) begin
            if (wr.wr_val[i] == ARM_VAL) begin
               val_next[i] = ARM_VAL; // Arming write is always taken
               arm_next[i] = 1'b1;
            end else begin
               if (arm_reg[i]) begin
                  val_next[i] = ~ARM_VAL;
               end
               arm_next[i] = 1'b0;
            end
         end else if (intervene) begin
            arm_next[i] = 1'b0;
         end
      end
   end
   // Registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         val_reg <= RST_VAL;
         arm_reg <= '0;
      end else begin
         val_reg <= val_next;
         arm_reg <= arm_next;
      end
   end
   // Per-bit check that an unarmed opposite write leaves the bit alone
   for (genvar g = 0; g < W; g++) begin : g_chk
      property p_no_unarmed_set;
         @(posedge clk) disable iff (sys_rst)
         (wr.wr_en[g] && !arm_reg[g] && wr.wr_val[g] != ARM_VAL)
         |=> val_reg[g] == $past(val_reg[g]);
      endproperty
      a_no_unarmed_set: assert property (p_no_unarmed_set)
         else $error("Protected bit changed unarmed");
   end
   property p_arm_then_take;
      @(posedge clk) disable iff (sys_rst)
      (arm_reg[0] && wr.wr_en[0] && wr.wr_val[0] != ARM_VAL) |=> val_reg[0] != ARM_VAL;
   endproperty
   a_arm_then_take: assert property (p_arm_then_take)
      else $error("Armed opposite write not taken");
endmodule

// file: dv/frc_cpu_model.sv
// Model of the CPU core with its interrupt and transfer controllers
`timescale 1ns/1ps
module frc_cpu_model (
   input wire logic clk, // System clock
   output logic irq_accept, // Maskable interrupt accepted
   output logic nmi_accept, // Watchdog, oscillator or voltage interrupt
   output logic xfer_active, // Transfer controller busy
   output logic susp_wr_en, // Software write strobe for suspend request
   output logic susp_wr_val // Software write value
);
   // ****************************************
   // Idle levels; only maskable and the three listed sources are ever raised
   // ****************************************
   // No stop, wait or blank check request is ever issued
   initial begin
      irq_accept = 1'b0;
      nmi_accept = 1'b0;
      xfer_active = 1'b0;
      susp_wr_en = 1'b0;
      susp_wr_val = 1'b0;
   end
   // Each task starts at a falling edge and ends one falling edge later
   task pulse_irq;
      irq_accept = 1'b1;
      @(negedge clk) irq_accept = 1'b0;
   endtask
   task pulse_nmi;
      nmi_accept = 1'b1;
      @(negedge clk) nmi_accept = 1'b0;
   endtask
   task pulse_xfer;
      xfer_active = 1'b1;
      @(negedge clk) xfer_active = 1'b0;
   endtask
   // Handler or software write of the suspend request bit
   task sw_suspend(input logic v);
      susp_wr_en = 1'b1;
      susp_wr_val = v;
      @(negedge clk) susp_wr_en = 1'b0;
   endtask
endmodule

// file: dv/flash_rewrite_interrupt_control_tb.sv
// Self-checking testbench of the flash rewrite interrupt controller
`timescale 1ns/1ps
module flash_rewrite_interrupt_control_tb;
   import frc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_start = 1'b0;
   frc_op_t cmd_op = FRC_OP_ERASE;
   logic cmd_prog_area = 1'b0;
   logic [3:0] cmd_block = 4'h0;
   logic flash_op_done = 1'b0;
   logic [5:0] set_wr_en = 6'h00;
   logic [5:0] set_wr_val = 6'h00;
   logic [3:0] lock_wr_en = 4'h0;
   logic [3:0] lock_wr_val = 4'h0;
   logic [3:0] acc_block = 4'h0;
   logic irq_accept, nmi_accept, xfer_active, susp_wr_en, susp_wr_val;
   logic erase_suspend_request, flash_ready_flag, erase_suspended, erase_run;
   logic flash_reset, irq_hold, acc_allowed, watchdog_run;
   logic [5:0] mode_bits;
   logic [3:0] lock_bits;
   int n_mismatch = 0;
   int comparisons = 0;
   int seed = 28921;
   int cnt;
   logic [3:0] blk, oth;
   // Clock of 4 ns
   always #2 clk = ~clk;
   frc_ctrl u_dut (.clk, .sys_rst, .cmd_start, .cmd_op, .cmd_prog_area, .cmd_block,
      .flash_op_done, .irq_accept, .nmi_accept, .xfer_active, .susp_wr_en, .susp_wr_val,
      .set_wr_en, .set_wr_val, .lock_wr_en, .lock_wr_val, .acc_block,
      .erase_suspend_request, .flash_ready_flag, .erase_suspended, .erase_run,
      .flash_reset, .irq_hold, .acc_allowed, .watchdog_run, .mode_bits, .lock_bits);
   frc_cpu_model u_cpu (.clk, .irq_accept, .nmi_accept, .xfer_active, .susp_wr_en,
      .susp_wr_val);
   // ****************************************
   // Compare, expectation and closing helpers
   // ****************************************
   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_vec(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_cnt(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function logic exp_prot(input logic first, input logic gap);
      return gap ? first : ~first;
   endfunction
   function logic exp_acc(input logic [3:0] a, input logic [3:0] s);
      return a != s;
   endfunction
   task conclude;
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // Stimulus tasks, all entered at a falling edge
   // ****************************************
   task wr_bits(input logic lock, input int idx, input logic v);
      @(negedge clk);
      if (lock) lock_wr_en = 4'h1 << idx;
      else set_wr_en = 6'h01 << idx;
      lock_wr_val = {4{v}};
      set_wr_val = {6{v}};
      @(negedge clk);
      lock_wr_en = 4'h0;
      set_wr_en = 6'h00;
   endtask
   task prot_pair(input logic lock, input int idx, input logic first, input logic gap);
      wr_bits(lock, idx, first);
      if (gap) u_cpu.pulse_xfer();
      wr_bits(lock, idx, ~first);
      repeat (3) @(negedge clk);
      if (lock) chk_bit(lock_bits[idx], exp_prot(first, gap));
      else chk_bit(mode_bits[idx], exp_prot(first, gap));
   endtask
   task start_cmd(input frc_op_t op, input logic prog);
      blk = 4'($random(seed)) | 4'h1; // Block 0 never targeted
      oth = blk ^ (4'($random(seed)) | 4'h1);
      @(negedge clk);
      cmd_start = 1'b1;
      cmd_op = op;
      cmd_prog_area = prog;
      cmd_block = blk;
      @(negedge clk) cmd_start = 1'b0;
      for (cnt = 0; cnt < 8 && erase_run !== 1'b1; cnt++) @(negedge clk);
      chk_bit(erase_run, 1'b1);
      chk_bit(flash_ready_flag, 1'b0);
      chk_bit(watchdog_run, 1'b1);
   endtask
   task finish_op;
      @(negedge clk) flash_op_done = 1'b1;
      @(negedge clk) flash_op_done = 1'b0;
      for (cnt = 0; cnt < 8 && flash_ready_flag !== 1'b1; cnt++) @(negedge clk);
      chk_bit(flash_ready_flag, 1'b1);
      chk_bit(erase_run, 1'b0);
   endtask
   task run_suspend(input logic auto_on);
      start_cmd(FRC_OP_ERASE, 1'b0);
      repeat ($random(seed) & 3) @(negedge clk);
      u_cpu.pulse_irq();
      if (!auto_on) begin
         repeat (3) @(negedge clk);
         chk_bit(erase_suspend_request, 1'b0);
         chk_bit(erase_run, 1'b1);
         u_cpu.sw_suspend(1'b1);
      end
      for (cnt = 0; cnt < 8 && erase_suspend_request !== 1'b1; cnt++) @(negedge clk);
      chk_bit(erase_suspend_request, 1'b1);
      for (cnt = 0; cnt < 20 && erase_suspended !== 1'b1; cnt++) @(negedge clk);
      chk_cnt(cnt, SUSPEND_LATENCY_CYC);
      acc_block = blk;
      repeat (2) @(negedge clk);
      chk_bit(acc_allowed, exp_acc(blk, blk));
      acc_block = oth;
      repeat (2) @(negedge clk);
      chk_bit(acc_allowed, exp_acc(oth, blk));
      u_cpu.sw_suspend(1'b0);
      repeat (3) @(negedge clk);
      chk_bit(erase_suspend_request, 1'b0);
      chk_bit(erase_suspended, 1'b0);
      chk_bit(erase_run, 1'b1);
      finish_op();
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      chk_vec({erase_suspend_request, flash_ready_flag, erase_suspended, erase_run,
         flash_reset, irq_hold, acc_allowed, watchdog_run}, 8'h43);
      chk_vec({mode_bits, 2'h0}, 8'h00);
      chk_vec({lock_bits, 4'h0}, 8'hF0);
      // Each set-protected bit is written 0 then 1, once with a transfer between the writes and once without
      for (int i = 0; i < 6; i++) begin
         prot_pair(1'b0, i, 1'b0, 1'b1);
         prot_pair(1'b0, i, 1'b0, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         prot_pair(1'b1, i, 1'b1, 1'b1);
         prot_pair(1'b1, i, 1'b1, 1'b0);
      end
      run_suspend(1'b1);
      wr_bits(1'b0, SB_SUSP_ON_INT, 1'b0);
      repeat (3) @(negedge clk);
      chk_bit(mode_bits[SB_SUSP_ON_INT], 1'b0);
      run_suspend(1'b0);
      start_cmd(FRC_OP_PROGRAM, 1'b0);
      u_cpu.pulse_irq();
      u_cpu.pulse_nmi();
      repeat (3) @(negedge clk);
      chk_bit(erase_run, 1'b1);
      chk_bit(irq_hold, 1'b0);
      finish_op();
      for (int k = 0; k < 2; k++) begin
         start_cmd(k ? FRC_OP_PROGRAM : FRC_OP_ERASE, 1'b1);
         u_cpu.pulse_nmi();
         for (cnt = 0; cnt < 8 && flash_reset !== 1'b1; cnt++) @(negedge clk);
         chk_bit(flash_reset, 1'b1);
         chk_bit(erase_run, 1'b0);
         for (cnt = 0; cnt < 40 && irq_hold === 1'b1; cnt++) @(negedge clk);
         chk_cnt(cnt, RESTART_DELAY_CYC);
         for (cnt = 0; cnt < 20 && flash_ready_flag !== 1'b1; cnt++) @(negedge clk);
         chk_bit(flash_ready_flag, 1'b1);
      end
      start_cmd(FRC_OP_ERASE, 1'b1);
      finish_op();
      conclude();
   end
   // Watchdog against a hung run
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
endmodule
